/* File: ddl_pkg.sv */
// Shared constants and types for the debug link access-layer control block.
package ddl_pkg;

    // ========================================================================
    // Register offsets
    localparam logic [3:0] OFS_REV_STATUS = 4'h0;
    localparam logic [3:0] OFS_ERR_STATUS = 4'h1;
    localparam logic [3:0] OFS_PHY_CTRL_A = 4'h2;
    localparam logic [3:0] OFS_PHY_CTRL_B = 4'h3;
    localparam logic [3:0] OFS_KEY_STATUS = 4'h7;
    localparam logic [3:0] OFS_RESET_REQ = 4'h8;
    localparam logic [3:0] OFS_CLK_SELECT = 4'h9;
    localparam logic [3:0] OFS_SYS_CTRL = 4'ha;
    localparam logic [3:0] OFS_SYS_STATUS = 4'hb;
    localparam logic [3:0] OFS_CRC_STATUS = 4'hc;

    // ========================================================================
    // Field positions
    localparam int REV_LSB = 4;
    localparam int PHY_CONTROL_B_DISABLE_BIT = 2;
    localparam int KEY_UROW_BIT = 5;
    localparam int KEY_NVM_BIT = 4;
    localparam int KEY_ERASE_BIT = 3;
    localparam int SYSCTRL_FINAL_BIT = 1;
    localparam int SYSCTRL_SYSTEM_CLOCK_REQUEST_BIT = 0;
    localparam int SYSST_RSTSYS_BIT = 5;
    localparam int SYSST_SLEEP_BIT = 4;
    localparam int SYSST_NVM_BIT = 3;
    localparam int SYSST_UROW_BIT = 2;
    localparam int SYSST_LOCK_BIT = 0;

    // ========================================================================
    // Values after reset and codes
    localparam logic [7:0] RST_PHY_CTRL = 8'h00;
    localparam logic [1:0] RST_CLK_SELECT = 2'h2;
    localparam logic RST_SYSTEM_CLOCK_REQUEST = 1'b1;
    localparam logic [7:0] RESET_SIGNATURE = 8'h59;
    // Revision value is arbitrary.
    localparam logic [3:0] LINK_REVISION = 4'h3;
    localparam int UROW_BYTES = 32;
    localparam logic [4:0] UROW_LAST = 5'h1f;
    localparam int SYNC_STAGES = 2;

    typedef enum logic [1:0] {
        KEY_NONE = 2'b00,
        KEY_ERASE = 2'b01,
        KEY_NVM = 2'b10,
        KEY_UROW = 2'b11
    } ddl_key_e;

    typedef enum logic [2:0] {
        ERR_NONE = 3'h0,
        ERR_PARITY = 3'h1,
        ERR_FRAME = 3'h2,
        ERR_TIMEOUT = 3'h3,
        ERR_CLOCK = 3'h4,
        ERR_CONTENTION = 3'h7
    } ddl_err_e;

    typedef enum logic [2:0] {
        ST_IDLE = 3'b000,
        ST_INRST = 3'b001,
        ST_ACTIVE = 3'b010,
        ST_COPY = 3'b011,
        ST_DONE = 3'b100,
        ST_FINRST = 3'b101
    } ddl_state_e;

    typedef struct packed {
        logic wr;
        logic rd;
        logic [3:0] addr;
        logic [7:0] data;
    } ddl_reg_req_s;

    typedef struct packed {
        logic wr;
        logic rd;
        logic [15:0] addr;
        logic [7:0] data;
    } ddl_mem_req_s;

    typedef struct packed {
        logic sysRstActive;
        logic sysSleep;
        logic lockState;
        logic [2:0] crcStatus;
    } ddl_sys_s;

endpackage

/* File: ddl_sync2.sv */
// Two-stage synchroniser for levels arriving from the system domain.
`timescale 1ns/1ns
module ddl_sync2 #(
    parameter int WIDTH = 1
) (
    input wire logic clk,
    input wire logic nrst,
    input wire logic ce,
    input wire logic [WIDTH-1:0] din,
    output logic [WIDTH-1:0] dout
);
    logic [WIDTH-1:0] meta_r;

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            meta_r <= '0;
            dout <= '0;
        end else if (ce) begin
            meta_r <= din;
            dout <= meta_r;
        end
    end
endmodule

/* File: ddl_access_ctrl.sv */
// Access-layer control of the debug link: keys, reset request, user row buffer, status registers.
//
// Overview of operation
// [RL1] - Debugger erases locked part, then enters program key.
// [RL2] - Key, reset signature, then 0x00 releases reset.
// [RL3] - NVM-programming status sets after key and reset.
// [RL4] - After NVM writes, reset cycle ends programming.
// [RL5] - Debugger avoids direct NVM writes while CPU runs.
// [RL6] - User-row key plus reset sets user-row status.
// [RL7] - User-row mode accepts writes to first 32 bytes.
// [RL8] - Completion copies buffered bytes one-to-one into row.
// [RL9] - Final-write bit starts copy; status clears when done.
// [RL10] - Debugger clears user-row key, then resets again.
// [RL11] - User-row mode never returns SRAM read data.
// [RL12] - Every sync rising edge emits an event.
// [RL13] - Link layer stays reachable in all sleep modes.
// [RL14] - Stopped system clock blocks system bus access.
// [RL15] - Sleep status reads set in idle or deeper.
// [RL16] - Clock request, default one, keeps bus usable.
// [RL17] - Registers reachable only through the link port.
// [RL18] - Offsets 0-3 physical layer, 4-C access layer.
// [RL19] - Status bits 7:4 report link revision.
// [RL20] - Error signature latched, cleared by debugger read.
// [RL21] - Reset signature asserts reset; other values release.
`timescale 1ns/1ns
module ddl_access_ctrl (
    input wire logic clk,
    input wire logic nrst,
    input wire logic ce,
    input wire ddl_pkg::ddl_reg_req_s regReq,
    output logic [7:0] regRdData_r,
    output logic regRdValid_r,
    input wire logic keyValid,
    input wire ddl_pkg::ddl_key_e keyId,
    input wire logic errValid,
    input wire ddl_pkg::ddl_err_e errCode,
    input wire logic syncEdge,
    output logic syncEvent_r,
    input wire ddl_pkg::ddl_sys_s sysIn,
    output logic sysResetReq_r,
    output logic sysClockRequest_r,
    output logic sysBusOk_r,
    output logic linkClockReq_r,
    output logic chipEraseStart_r,
    output logic nvmProgramActive_r,
    output logic userRowProgramActive_r,
    output logic [7:0] phyCtrlA_r,
    output logic [7:0] phyCtrlB_r,
    output logic [1:0] linkClkSel_r,
    input wire ddl_pkg::ddl_mem_req_s memReq,
    output ddl_pkg::ddl_mem_req_s ramReq_r,
    output logic memRdBlocked_r,
    output logic rowWrEn_r,
    output logic [4:0] rowAddr_r,
    output logic [7:0] rowData_r
);
    // ========================================================================
    // System domain inputs
    ddl_pkg::ddl_sys_s sysSync;

    ddl_sync2 #(
        .WIDTH($bits(ddl_pkg::ddl_sys_s))
    ) uSysSync (
        .clk(clk),
        .nrst(nrst),
        .ce(ce),
        .din(sysIn),
        .dout(sysSync)
    );

    // ========================================================================
    // Register write and error-read decode
    logic wrRevSt, wrCtrlA, wrCtrlB, wrKey, wrRst, wrClk, wrSys;
    logic rdErr;
    logic disableWr;
    logic rstAssertWr;
    logic rstReleaseWr;
    logic finalWr;

    // Only the link-side register port reaches these registers. [RL17]
    assign wrRevSt = regReq.wr && (regReq.addr == ddl_pkg::OFS_REV_STATUS);
    assign wrCtrlA = regReq.wr && (regReq.addr == ddl_pkg::OFS_PHY_CTRL_A);
    assign wrCtrlB = regReq.wr && (regReq.addr == ddl_pkg::OFS_PHY_CTRL_B);
    assign wrKey = regReq.wr && (regReq.addr == ddl_pkg::OFS_KEY_STATUS);
    assign wrRst = regReq.wr && (regReq.addr == ddl_pkg::OFS_RESET_REQ);
    assign wrClk = regReq.wr && (regReq.addr == ddl_pkg::OFS_CLK_SELECT);
    assign wrSys = regReq.wr && (regReq.addr == ddl_pkg::OFS_SYS_CTRL);
    assign rdErr = regReq.rd && (regReq.addr == ddl_pkg::OFS_ERR_STATUS);
    assign disableWr = wrCtrlB && regReq.data[ddl_pkg::PHY_CONTROL_B_DISABLE_BIT];
    assign rstAssertWr = wrRst && (regReq.data == ddl_pkg::RESET_SIGNATURE); // [RL21]
    assign rstReleaseWr = wrRst && (regReq.data != ddl_pkg::RESET_SIGNATURE); // [RL21] [RL2]
    assign finalWr = wrSys && regReq.data[ddl_pkg::SYSCTRL_FINAL_BIT];

    // ========================================================================
    // Physical layer configuration
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            phyCtrlA_r <= ddl_pkg::RST_PHY_CTRL;
            phyCtrlB_r <= ddl_pkg::RST_PHY_CTRL;
            linkClkSel_r <= ddl_pkg::RST_CLK_SELECT;
        end else if (ce) begin
            if (disableWr) begin
                // Disabling resets control A and clock select; control B takes the whole written byte.
                phyCtrlA_r <= ddl_pkg::RST_PHY_CTRL;
                phyCtrlB_r <= regReq.data;
                linkClkSel_r <= ddl_pkg::RST_CLK_SELECT;
            end else begin
                if (wrCtrlA) begin
                    phyCtrlA_r <= regReq.data; // [RL18]
                end
                if (wrCtrlB) begin
                    phyCtrlB_r <= regReq.data; // [RL18]
                end
                if (wrClk) begin
                    linkClkSel_r <= regReq.data[1:0];
                end
            end
        end
    end

    // The link keeps its own clock whatever the sleep state, unless disabled.
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            linkClockReq_r <= 1'b1;
        end else if (ce) begin
            linkClockReq_r <= !phyCtrlB_r[ddl_pkg::PHY_CONTROL_B_DISABLE_BIT]; // [RL13]
        end
    end

    // ========================================================================
    // Error signature
    logic [2:0] errSig_r;

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            errSig_r <= ddl_pkg::ERR_NONE;
        end else if (ce) begin
            // A new error in the read cycle survives the clear.
            if (errValid) begin
                errSig_r <= errCode; // [RL20]
            end else if (rdErr || disableWr) begin
                errSig_r <= ddl_pkg::ERR_NONE; // [RL20]
            end
        end
    end

    // ========================================================================
    // Reset request and system control
    logic system_clock_request_r;
    logic finalPending_r;

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            sysResetReq_r <= 1'b0;
        end else if (ce) begin
            if (rstAssertWr) begin
                sysResetReq_r <= 1'b1; // [RL21]
            end else if (rstReleaseWr || disableWr) begin
                sysResetReq_r <= 1'b0; // [RL21]
            end
        end
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            system_clock_request_r <= ddl_pkg::RST_SYSTEM_CLOCK_REQUEST;
        end else if (ce && wrSys) begin
            system_clock_request_r <= regReq.data[ddl_pkg::SYSCTRL_SYSTEM_CLOCK_REQUEST_BIT]; // [RL16]
        end
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            sysClockRequest_r <= ddl_pkg::RST_SYSTEM_CLOCK_REQUEST;
            sysBusOk_r <= 1'b0;
        end else if (ce) begin
            sysClockRequest_r <= system_clock_request_r; // [RL16]
            // With the clock requested, sleep is only emulated and the bus stays usable.
            sysBusOk_r <= !sysSync.sysSleep || system_clock_request_r; // [RL14] [RL16]
        end
    end

    // ========================================================================
    // Keys
    logic eraseKey_r, nvmKey_r, urowKey_r;
    ddl_pkg::ddl_state_e state_r, state_nxt;
    logic modeNvm_r, modeNvm_nxt;
    logic eraseDone;

    assign eraseDone = (state_r == ddl_pkg::ST_IDLE) && !sysSync.lockState && !sysResetReq_r;

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            eraseKey_r <= 1'b0;
            nvmKey_r <= 1'b0;
            urowKey_r <= 1'b0;
        end else if (ce) begin
            if (disableWr) begin
                eraseKey_r <= 1'b0;
                nvmKey_r <= 1'b0;
                urowKey_r <= 1'b0;
            end else begin
                if (keyValid && keyId == ddl_pkg::KEY_ERASE) begin
                    eraseKey_r <= 1'b1; // [RL1]
                end else if (eraseKey_r && eraseDone) begin
                    eraseKey_r <= 1'b0;
                end
                // The program key ends with the closing reset cycle.
                if (keyValid && keyId == ddl_pkg::KEY_NVM) begin
                    nvmKey_r <= 1'b1; // [RL1]
                end else if (state_r == ddl_pkg::ST_FINRST && rstReleaseWr && modeNvm_r) begin
                    nvmKey_r <= 1'b0; // [RL4]
                end
                if (keyValid && keyId == ddl_pkg::KEY_UROW) begin
                    urowKey_r <= 1'b1; // [RL6]
                end else if (wrKey && regReq.data[ddl_pkg::KEY_UROW_BIT]) begin
                    urowKey_r <= 1'b0; // [RL10]
                end
            end
        end
    end

    // ========================================================================
    // Programming sequence
    logic [4:0] copyIdx_r;

    always_comb begin
        state_nxt = state_r;
        modeNvm_nxt = modeNvm_r;
        case (state_r)
            ddl_pkg::ST_IDLE: begin
                if (rstAssertWr) begin
                    state_nxt = ddl_pkg::ST_INRST; // [RL2]
                end
            end
            ddl_pkg::ST_INRST: begin
                if (rstReleaseWr) begin
                    // NVM programming needs a cleared lock; user row needs a set one.
                    if (nvmKey_r && !sysSync.lockState) begin
                        state_nxt = ddl_pkg::ST_ACTIVE; // [RL3]
                        modeNvm_nxt = 1'b1;
                    end else if (urowKey_r && sysSync.lockState) begin
                        state_nxt = ddl_pkg::ST_ACTIVE; // [RL6]
                        modeNvm_nxt = 1'b0;
                    end else begin
                        state_nxt = ddl_pkg::ST_IDLE;
                    end
                end
            end
            ddl_pkg::ST_ACTIVE: begin
                if (rstAssertWr) begin
                    state_nxt = ddl_pkg::ST_FINRST; // [RL4]
                end else if (!modeNvm_r && finalWr) begin
                    state_nxt = ddl_pkg::ST_COPY; // [RL9]
                end
            end
            ddl_pkg::ST_COPY: begin
                if (copyIdx_r == ddl_pkg::UROW_LAST) begin
                    state_nxt = ddl_pkg::ST_DONE; // [RL9]
                end
            end
            ddl_pkg::ST_DONE: begin
                if (rstAssertWr) begin
                    state_nxt = ddl_pkg::ST_FINRST; // [RL10]
                end
            end
            ddl_pkg::ST_FINRST: begin
                if (rstReleaseWr) begin
                    state_nxt = ddl_pkg::ST_IDLE; // [RL4]
                end
            end
            default: begin
                state_nxt = ddl_pkg::ST_IDLE;
            end
        endcase
        if (disableWr) begin
            state_nxt = ddl_pkg::ST_IDLE;
        end
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            state_r <= ddl_pkg::ST_IDLE;
            modeNvm_r <= 1'b0;
        end else if (ce) begin
            state_r <= state_nxt;
            modeNvm_r <= modeNvm_nxt;
        end
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            nvmProgramActive_r <= 1'b0;
            userRowProgramActive_r <= 1'b0;
            chipEraseStart_r <= 1'b0;
            finalPending_r <= 1'b0;
        end else if (ce) begin
            nvmProgramActive_r <= (state_nxt == ddl_pkg::ST_ACTIVE) && modeNvm_nxt; // [RL3]
            userRowProgramActive_r <= ((state_nxt == ddl_pkg::ST_ACTIVE) ||
                (state_nxt == ddl_pkg::ST_COPY)) && !modeNvm_nxt; // [RL6] [RL9]
            chipEraseStart_r <= (state_r == ddl_pkg::ST_INRST) && rstReleaseWr && eraseKey_r;
            finalPending_r <= (state_nxt == ddl_pkg::ST_COPY);
        end
    end

    // ========================================================================
    // User row buffer and copy
    logic [7:0] rowBuf [ddl_pkg::UROW_BYTES];
    logic inRowWindow;

    assign inRowWindow = (memReq.addr < 16'(ddl_pkg::UROW_BYTES));

    always_ff @(posedge clk) begin
        if (ce && memReq.wr && userRowProgramActive_r && inRowWindow &&
            state_r == ddl_pkg::ST_ACTIVE) begin
            rowBuf[memReq.addr[4:0]] <= memReq.data; // [RL7]
        end
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            copyIdx_r <= 5'h00;
            rowWrEn_r <= 1'b0;
            rowAddr_r <= 5'h00;
            rowData_r <= 8'h00;
        end else if (ce) begin
            rowWrEn_r <= (state_r == ddl_pkg::ST_COPY);
            if (state_r == ddl_pkg::ST_COPY) begin
                rowAddr_r <= copyIdx_r; // [RL8]
                rowData_r <= rowBuf[copyIdx_r]; // [RL8]
                copyIdx_r <= copyIdx_r + 5'h01;
            end else begin
                copyIdx_r <= 5'h00;
            end
        end
    end

    // ========================================================================
    // Memory path towards the system bus
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            ramReq_r <= '0;
            memRdBlocked_r <= 1'b0;
        end else if (ce) begin
            ramReq_r <= memReq;
            // Out-of-window user-row writes are dropped without any error reply.
            ramReq_r.wr <= memReq.wr && sysBusOk_r &&
                (!userRowProgramActive_r || inRowWindow); // [RL7] [RL14]
            // Reads during user-row mode would leak SRAM on a locked part.
            ramReq_r.rd <= memReq.rd && sysBusOk_r && !userRowProgramActive_r; // [RL11] [RL14]
            memRdBlocked_r <= memReq.rd && userRowProgramActive_r; // [RL11]
        end
    end

    // ========================================================================
    // Sync edge event
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            syncEvent_r <= 1'b0;
        end else if (ce) begin
            syncEvent_r <= syncEdge; // [RL12]
        end
    end

    // ========================================================================
    // Register read
    logic [7:0] rdMux;

    always_comb begin
        rdMux = 8'h00;
        case (regReq.addr)
            ddl_pkg::OFS_REV_STATUS: rdMux[7:ddl_pkg::REV_LSB] = ddl_pkg::LINK_REVISION; // [RL19]
            ddl_pkg::OFS_ERR_STATUS: rdMux[2:0] = errSig_r; // [RL20]
            ddl_pkg::OFS_PHY_CTRL_A: rdMux = phyCtrlA_r;
            ddl_pkg::OFS_PHY_CTRL_B: rdMux = phyCtrlB_r;
            ddl_pkg::OFS_KEY_STATUS: begin
                rdMux[ddl_pkg::KEY_UROW_BIT] = urowKey_r;
                rdMux[ddl_pkg::KEY_NVM_BIT] = nvmKey_r;
                rdMux[ddl_pkg::KEY_ERASE_BIT] = eraseKey_r;
            end
            ddl_pkg::OFS_RESET_REQ: rdMux[0] = sysResetReq_r; // [RL21]
            ddl_pkg::OFS_CLK_SELECT: rdMux[1:0] = linkClkSel_r;
            ddl_pkg::OFS_SYS_CTRL: begin
                rdMux[ddl_pkg::SYSCTRL_FINAL_BIT] = finalPending_r;
                rdMux[ddl_pkg::SYSCTRL_SYSTEM_CLOCK_REQUEST_BIT] = system_clock_request_r;
            end
            ddl_pkg::OFS_SYS_STATUS: begin
                rdMux[ddl_pkg::SYSST_RSTSYS_BIT] = sysSync.sysRstActive;
                rdMux[ddl_pkg::SYSST_SLEEP_BIT] = sysSync.sysSleep; // [RL15]
                rdMux[ddl_pkg::SYSST_NVM_BIT] = nvmProgramActive_r; // [RL3]
                rdMux[ddl_pkg::SYSST_UROW_BIT] = userRowProgramActive_r; // [RL6] [RL9]
                rdMux[ddl_pkg::SYSST_LOCK_BIT] = sysSync.lockState;
            end
            ddl_pkg::OFS_CRC_STATUS: rdMux[2:0] = sysSync.crcStatus;
            default: rdMux = 8'h00;
        endcase
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            regRdData_r <= 8'h00;
            regRdValid_r <= 1'b0;
        end else if (ce) begin
            regRdValid_r <= regReq.rd;
            if (regReq.rd) begin
                regRdData_r <= rdMux; // [RL18]
            end
        end
    end

    // Writes to the revision register are accepted but have no effect.
    logic unusedRevWr;
    assign unusedRevWr = wrRevSt;

endmodule

/* File: ddl_access_ctrl_monitor.sv */
// Checker for the access-layer control block ports.
`timescale 1ns/1ns
module ddl_access_ctrl_monitor (
    input wire logic clk,
    input wire logic nrst,
    input wire logic ce,
    input wire ddl_pkg::ddl_reg_req_s regReq,
    input wire logic regRdValid_r,
    input wire logic syncEdge,
    input wire logic syncEvent_r,
    input wire logic sysResetReq_r,
    input wire logic linkClockReq_r,
    input wire logic userRowProgramActive_r,
    input wire ddl_pkg::ddl_mem_req_s memReq,
    input wire ddl_pkg::ddl_mem_req_s ramReq_r,
    input wire logic memRdBlocked_r,
    input wire logic rowWrEn_r,
    input wire logic [4:0] rowAddr_r
);
    // ====================
    // Port relations
    logic rowMode;
    logic rstWr;
    assign rowMode = ce && userRowProgramActive_r;
    assign rstWr = ce && regReq.wr && regReq.addr == 4'h8;
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!nrst);
    a_read_answer_pulse: assert property (ce && regReq.rd |=> regRdValid_r)
        else $error("read answer missing");
    a_sync_event_copy: assert property (ce && syncEdge |=> syncEvent_r)
        else $error("sync event missing");
    a_reset_set_code: assert property (rstWr && regReq.data == 8'h59 |=> sysResetReq_r)
        else $error("reset request not set");
    a_reset_clear_code: assert property (rstWr && regReq.data != 8'h59 |=> !sysResetReq_r)
        else $error("reset request not cleared");
    a_link_clock_req: assert property (ce && regReq.wr && regReq.addr == 4'h3
        |-> ##2 linkClockReq_r != $past(regReq.data[2], 2))
        else $error("link clock request wrong");
    a_row_read_block: assert property (rowMode && memReq.rd |=> memRdBlocked_r && !ramReq_r.rd)
        else $error("read leaked in row mode");
    a_row_write_limit: assert property (rowMode && memReq.wr && memReq.addr > 16'h001f |=> !ramReq_r.wr)
        else $error("row write out of range");
    a_row_copy_step: assert property (ce && rowWrEn_r && rowAddr_r != 5'h1f
        |=> rowWrEn_r && rowAddr_r == $past(rowAddr_r) + 5'h01)
        else $error("row copy sequence broken");
endmodule

bind ddl_access_ctrl ddl_access_ctrl_monitor mon (.clk, .nrst, .ce, .regReq, .regRdValid_r, .syncEdge,
    .syncEvent_r, .sysResetReq_r, .linkClockReq_r, .userRowProgramActive_r, .memReq, .ramReq_r,
    .memRdBlocked_r, .rowWrEn_r, .rowAddr_r);

/* File: ddl_debugger_model.sv */
// Debugger model issuing register, key and memory requests.
`timescale 1ns/1ns
module ddl_debugger_model (
    input wire logic clk,
    input wire logic [7:0] regRdData_r,
    input wire logic regRdValid_r,
    output ddl_pkg::ddl_reg_req_s regReq,
    output logic keyValid,
    output ddl_pkg::ddl_key_e keyId,
    output ddl_pkg::ddl_mem_req_s memReq
);
    initial begin
        regReq = '0;
        keyValid = 1'b0;
        keyId = ddl_pkg::KEY_NONE;
        memReq = '0;
    end
    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        @(posedge clk);
        regReq <= {1'b1, 1'b0, a, d};
        @(posedge clk);
        regReq <= '0;
    endtask
    // Data without the valid strobe reads as unknown so it never matches.
    task automatic rd(input logic [3:0] a, output logic [7:0] d);
        @(posedge clk);
        regReq <= {1'b0, 1'b1, a, 8'h00};
        @(posedge clk);
        regReq <= '0;
        #1;
        d = regRdValid_r ? regRdData_r : 8'hxx;
    endtask
    task automatic key(input ddl_pkg::ddl_key_e k);
        @(posedge clk);
        keyValid <= 1'b1;
        keyId <= k;
        @(posedge clk);
        keyValid <= 1'b0;
    endtask
    task automatic mem(input logic w, input logic r, input logic [15:0] a, input logic [7:0] d);
        @(posedge clk);
        memReq <= {w, r, a, d};
        @(posedge clk);
        memReq <= '0;
        #1;
    endtask
    task automatic rst_cycle();
        wr(4'h8, ddl_pkg::RESET_SIGNATURE);
        wr(4'h8, 8'h00);
    endtask
endmodule

/* File: ddl_access_ctrl_tb.sv */
// Self-checking testbench for the access-layer control block.
`timescale 1ns/1ns
module ddl_access_ctrl_tb;
    logic clk = 1'b0;
    logic nrst = 1'b0;
    logic ce = 1'b1;
    logic errValid = 1'b0;
    logic syncEdge = 1'b0;
    ddl_pkg::ddl_err_e errCode = ddl_pkg::ERR_NONE;
    ddl_pkg::ddl_sys_s sysIn = '0;
    ddl_pkg::ddl_reg_req_s regReq;
    ddl_pkg::ddl_key_e keyId;
    ddl_pkg::ddl_mem_req_s memReq, ramReq_r;
    logic [7:0] regRdData_r, rowData_r, d, got;
    logic regRdValid_r, keyValid, syncEvent_r, sysBusOk_r, memRdBlocked_r, rowWrEn_r;
    logic [4:0] rowAddr_r;
    int num_errors = 0;
    int compares = 0;
    int n;
    always #5 clk = ~clk;
    ddl_debugger_model dbg (.clk, .regRdData_r, .regRdValid_r, .regReq, .keyValid, .keyId, .memReq);
    ddl_access_ctrl dut (.clk, .nrst, .ce, .regReq, .regRdData_r, .regRdValid_r, .keyValid, .keyId,
        .errValid, .errCode, .syncEdge, .syncEvent_r, .sysIn, .sysResetReq_r(), .sysClockRequest_r(),
        .sysBusOk_r, .linkClockReq_r(), .chipEraseStart_r(), .nvmProgramActive_r(),
        .userRowProgramActive_r(), .phyCtrlA_r(), .phyCtrlB_r(), .linkClkSel_r(), .memReq, .ramReq_r,
        .memRdBlocked_r, .rowWrEn_r, .rowAddr_r, .rowData_r);
    task automatic chk(input string s, input logic [7:0] e, input logic [7:0] v);
        compares++;
        if (v !== e) begin
            num_errors++;
            $display("wrong value %s expected %h seen %h", s, e, v);
        end
    endtask
    task automatic rc(input string s, input logic [3:0] a, input logic [7:0] m, input logic [7:0] e);
        dbg.rd(a, d);
        chk(s, e, d & m);
    endtask
    task automatic t_regs();
        rc("revision", 4'h0, 8'hff, {ddl_pkg::LINK_REVISION, 4'h0});
        dbg.wr(4'h0, 8'h0f);
        rc("revision ro", 4'h0, 8'hff, {ddl_pkg::LINK_REVISION, 4'h0});
        rc("clksel", 4'h9, 8'hff, 8'h02);
        dbg.wr(4'h3, 8'h00);
        rc("system_clock_request", 4'ha, 8'h01, 8'h01);
        rc("unmapped", 4'h5, 8'hff, 8'h00);
    endtask
    task automatic t_errors();
        for (int i = 1; i < 8; i++) begin
            if (i == 5 || i == 6) continue;
            @(posedge clk);
            errValid <= 1'b1;
            errCode <= ddl_pkg::ddl_err_e'(i[2:0]);
            @(posedge clk);
            errValid <= 1'b0;
            rc("signature", 4'h1, 8'h07, i[7:0]);
            rc("sig cleared", 4'h1, 8'h07, 8'h00);
        end
    endtask
    task automatic t_sync();
        @(posedge clk);
        syncEdge <= 1'b1;
        @(posedge clk);
        syncEdge <= 1'b0;
        #1;
        chk("sync event", 8'h01, {7'h0, syncEvent_r});
    endtask
    task automatic t_nvm();
        dbg.key(ddl_pkg::KEY_NVM);
        rc("nvm key", 4'h7, 8'h10, 8'h10);
        dbg.wr(4'h8, 8'h59);
        rc("reset held", 4'h8, 8'hff, 8'h01);
        dbg.wr(4'h8, 8'h00);
        rc("nvm status", 4'hb, 8'h08, 8'h08);
        dbg.mem(1'b1, 1'b0, 16'h0100, 8'h3c);
        chk("nvm write", 8'h01, {7'h0, ramReq_r.wr});
        dbg.rst_cycle();
        rc("nvm done", 4'h7, 8'h10, 8'h00);
    endtask
    task automatic t_urow();
        sysIn.lockState <= 1'b1;
        dbg.key(ddl_pkg::KEY_UROW);
        dbg.rst_cycle();
        rc("row status", 4'hb, 8'h04, 8'h04);
        dbg.mem(1'b1, 1'b0, 16'h0005, 8'h5a);
        chk("row write", 8'h01, {7'h0, ramReq_r.wr});
        dbg.mem(1'b1, 1'b0, 16'h0020, 8'h11);
        chk("row drop", 8'h00, {7'h0, ramReq_r.wr});
        dbg.mem(1'b0, 1'b1, 16'h0005, 8'h00);
        chk("row read", 8'h02, {6'h0, memRdBlocked_r, ramReq_r.rd});
        dbg.wr(4'ha, 8'h03);
        n = 0;
        got = 8'hxx;
        repeat (40) begin
            @(posedge clk);
            #1;
            if (rowWrEn_r) begin
                n++;
                if (rowAddr_r == 5'h05) got = rowData_r;
            end
        end
        chk("row copies", 8'h20, n[7:0]);
        chk("row data", 8'h5a, got);
        rc("row idle", 4'hb, 8'h04, 8'h00);
        dbg.wr(4'h7, 8'h20);
        dbg.rst_cycle();
        rc("row key", 4'h7, 8'h20, 8'h00);
        sysIn.lockState <= 1'b0;
    endtask
    task automatic t_sleep();
        sysIn.sysSleep <= 1'b1;
        repeat (4) @(posedge clk);
        rc("in sleep", 4'hb, 8'h10, 8'h10);
        chk("bus kept", 8'h01, {7'h0, sysBusOk_r});
        dbg.wr(4'ha, 8'h00);
        dbg.mem(1'b0, 1'b1, 16'h0100, 8'h00);
        chk("bus off", 8'h00, {6'h0, sysBusOk_r, ramReq_r.rd});
        sysIn.sysSleep <= 1'b0;
        repeat (4) @(posedge clk);
        rc("awake", 4'hb, 8'h10, 8'h00);
    endtask
    task automatic tally_and_finish();
        if (num_errors == 0 && compares > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask
    initial begin
        repeat (3) @(posedge clk);
        nrst <= 1'b1;
        t_regs();
        t_errors();
        t_sync();
        t_nvm();
        t_urow();
        t_sleep();
        tally_and_finish();
    end
    // Tests need under 2000 cycles.
    initial begin
        #200000;
        num_errors++;
        tally_and_finish();
    end
endmodule
